// [verilog/amcr_pkg.sv]
// constants, field layouts and carrier types of the converter mode configuration registers
package amcr_pkg;

    // register indices; the byte address on the bus is four times the index
    localparam logic [7:0] IDX_STATUS = 8'h01;
    localparam logic [7:0] IDX_CONV   = 8'h03;
    localparam logic [7:0] IDX_PIN    = 8'h04;
    localparam logic [7:0] IDX_PWR    = 8'h05;

    // reset values
    localparam logic [7:0] RST_CONV = 8'h01;
    localparam logic [7:0] RST_PIN  = 8'h00;
    localparam logic [7:0] RST_PWR  = 8'h00;

    // conversion_mode_reg fields
    localparam int CONV_RSVD_BIT = 7;
    localparam int CONV_MODE_LSB = 5;
    localparam int CONV_SEL_BIT  = 4;
    localparam int CONV_DLY_LSB  = 0;
    // pin_config_reg fields
    localparam int PIN_CON_LSB   = 4;
    localparam int PIN_DIR_LSB   = 0;
    // power_iface_reg fields
    localparam int PWR_PD_BIT    = 7;
    localparam int PWR_STAT_BIT  = 6;
    localparam int PWR_CRC_BIT   = 5;
    localparam int PWR_ARST_BIT  = 4;
    localparam int PWR_DAT_LSB   = 0;
    // status register fields
    localparam int STS_CHECKSUM_ERROR_FLAG_BIT = 6;
    localparam int STS_CONV_BIT   = 1;
    localparam int STS_WAIT_BIT   = 0;

    // excitation scheme codes
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_CHOP   = 2'h1;
    localparam logic [1:0] MODE_AC2    = 2'h2;
    localparam logic [1:0] MODE_AC4    = 2'h3;

    // clock rate and start delays in ns per code; codes 14 and 15 are reserved and wait nothing
    localparam longint CLK_MHZ = 125;
    localparam longint DLY_NS [16] = '{
        0, 50000, 59000, 67000, 85000, 119000, 189000, 328000,
        605000, 1160000, 2250000, 4490000, 8930000, 17800000, 0, 0};

    typedef logic [21:0] amcr_dly_t [16];

    // least times, so the cycle counts round up
    function automatic amcr_dly_t amcr_dly_tab();
        amcr_dly_t t;
        for (int i = 0; i < 16; i++)
        begin
            t[i] = 22'((DLY_NS[i] * CLK_MHZ + 64'd999) / 64'd1000);
        end
        return t;
    endfunction

    localparam amcr_dly_t DLY_CYC = amcr_dly_tab();

    // configuration outputs toward converter and serial logic
    typedef struct packed {
        logic chop_en;
        logic ac_two_wire;
        logic ac_four_wire;
        logic soft_power_down;
        logic status_byte_enable;
        logic crc_check_enable;
        logic serial_auto_reset_enable;
    } amcr_cfg_t;

    // general-purpose pin drive
    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } amcr_pin_t;

endpackage

// [verilog/amcr_regs.sv]
// apb register bank with conversion start sequencing and general-purpose pin control
// Notes on behaviour
// RULE_01 - two-bit mode picks normal, chop, two-wire or four-wire ac excitation
// RULE_02 - conversion-mode bit: clear runs continuous conversions, set runs one per start
// RULE_03 - four-bit code sets the wait before each conversion start, reset code one
// RULE_04 - connection bit set attaches the pin function to its analog input
// RULE_05 - direction bit clear makes the pin an output, set makes it an input
// RULE_06 - pin data bit drives the pin level and reads back the pin level
// RULE_07 - power-down bit set stops the converter, clear resumes normal operation
// RULE_08 - status-byte enable bit adds a status byte to conversion data reads
// RULE_09 - crc enable bit turns on checksum verification of transferred data
// RULE_10 - auto-reset enable bit turns on the serial interface automatic reset
// RULE_11 - pin configuration register at index 04h, resets to 00h
// RULE_12 - power and pin data register at index 05h, resets to 00h
// RULE_13 - conversion mode register at index 03h, resets to 01h, top bit reserved
// RULE_14 - detected checksum error sets a flag that stays until the host clears it
// RULE_15 - a pin is driven only when connected and set to output
`timescale 1ns/1ps
`default_nettype none

module amcr_regs
    import amcr_pkg::*;
#(
    parameter int        ADDR_W = 8,
    parameter amcr_dly_t DELAY_CYCLES = DLY_CYC
)(
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // conversion control
    input  wire logic              start_pin,
    input  wire logic              conv_done,
    output logic                   conv_start,
    output logic                   conv_active,
    // serial interface hooks
    input  wire logic              crc_error,
    output amcr_cfg_t              cfg,
    // general-purpose pins on the analog inputs
    input  wire logic [3:0]        pin_in,
    output amcr_pin_t              pin
);

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CONV, ST_HOLD} amcr_state_t;

    logic [7:0]  conversion_mode_reg;
    logic [7:0]  pin_config_reg;
    logic [7:0]  power_iface_reg;
    logic        checksum_error_flag;
    amcr_state_t state;
    amcr_state_t next_state;
    logic [21:0] dly_cnt;
    logic [2:0]  start_sync;
    logic        start_lvl;
    logic        start_prev;
    logic [3:0]  pin_s1;
    logic [3:0]  pin_s2;
    logic [3:0]  pin_s3;
    logic [3:0]  pin_lvl;

    // bus decode
    wire         setup     = psel && !penable;
    wire         access    = psel && penable;
    wire         hit_sts   = paddr == ADDR_W'({IDX_STATUS, 2'b00});
    wire         hit_conv  = paddr == ADDR_W'({IDX_CONV, 2'b00});
    wire         hit_pin   = paddr == ADDR_W'({IDX_PIN, 2'b00});
    wire         hit_pwr   = paddr == ADDR_W'({IDX_PWR, 2'b00});
    wire         hit_any   = hit_sts || hit_conv || hit_pin || hit_pwr;
    wire         wr        = access && pwrite;
    wire         wr_conv   = wr && hit_conv;
    wire         wr_pin    = wr && hit_pin;
    wire         wr_pwr    = wr && hit_pwr;
    wire         clr_crc   = wr && hit_sts && pwdata[STS_CHECKSUM_ERROR_FLAG_BIT];

    // field views
    wire [1:0]   mode_sel  = conversion_mode_reg[CONV_MODE_LSB +: 2];
    wire         one_shot  = conversion_mode_reg[CONV_SEL_BIT];
    wire [3:0]   dly_code  = conversion_mode_reg[CONV_DLY_LSB +: 4];
    wire [3:0]   pin_con   = pin_config_reg[PIN_CON_LSB +: 4];
    wire [3:0]   pin_dir   = pin_config_reg[PIN_DIR_LSB +: 4];
    wire [3:0]   pin_dat   = power_iface_reg[PWR_DAT_LSB +: 4];
    wire         pwr_down  = power_iface_reg[PWR_PD_BIT];
    wire         start_ok  = start_lvl && !pwr_down;
    wire         start_new = start_lvl && !start_prev;
    wire [21:0]  dly_load  = DELAY_CYCLES[dly_code];

    // a connected input pin reads its synchronised level, every other pin reads its data bit
    wire [3:0]   pin_read  = (pin_con & pin_dir & pin_lvl) | (~(pin_con & pin_dir) & pin_dat); // RULE_06
    wire [7:0]   sts_view  = 8'((checksum_error_flag << STS_CHECKSUM_ERROR_FLAG_BIT)
                               | ((state == ST_CONV) << STS_CONV_BIT)
                               | ((state == ST_WAIT) << STS_WAIT_BIT));
    wire [7:0]   rd_mux    = hit_conv ? conversion_mode_reg :
                             hit_pin  ? pin_config_reg :
                             hit_pwr  ? {power_iface_reg[7:4], pin_read} :
                             hit_sts  ? sts_view : 8'h00;

    // read data is captured in the setup cycle so it comes from a flop with no wait state
    assign pready  = 1'b1;
    assign pslverr = access && !hit_any;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (setup && !pwrite)
            prdata <= {24'h00_0000, rd_mux};
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            conversion_mode_reg <= RST_CONV; // RULE_13
            pin_config_reg      <= RST_PIN;  // RULE_11
            power_iface_reg     <= RST_PWR;  // RULE_12
        end
        else
        begin
            if (wr_conv)
                conversion_mode_reg <= pwdata[7:0]; // RULE_13
            if (wr_pin)
                pin_config_reg <= pwdata[7:0]; // RULE_11
            if (wr_pwr)
                power_iface_reg <= pwdata[7:0]; // RULE_12
        end
    end

    // sticky error: a new error in the clearing cycle keeps the flag set
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            checksum_error_flag <= 1'b0;
        else if (crc_error && cfg.crc_check_enable)
            checksum_error_flag <= 1'b1; // RULE_14
        else if (clr_crc)
            checksum_error_flag <= 1'b0; // RULE_14
    end

    // pin synchronisers; a level counts once the second and third stage agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            start_sync <= 3'h0;
            start_lvl  <= 1'b0;
            start_prev <= 1'b0;
            pin_s1     <= 4'h0;
            pin_s2     <= 4'h0;
            pin_s3     <= 4'h0;
            pin_lvl    <= 4'h0;
        end
        else
        begin
            start_sync <= {start_sync[1:0], start_pin};
            if (start_sync[1] == start_sync[2])
                start_lvl <= start_sync[2];
            start_prev <= start_lvl;
            pin_s1     <= pin_in;
            pin_s2     <= pin_s1;
            pin_s3     <= pin_s2;
            pin_lvl    <= (pin_s2 & pin_s3) | (pin_lvl & (pin_s2 | pin_s3));
        end
    end

    // conversion start sequencing
    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (start_ok && (start_new || !one_shot))
                    next_state = ST_WAIT; // RULE_02
            ST_WAIT:
                if (dly_cnt == 22'h00_0000)
                    next_state = ST_CONV; // RULE_03
            ST_CONV:
                if (conv_done)
                begin
                    if (one_shot)
                        next_state = ST_HOLD; // RULE_02
                    else if (start_ok)
                        next_state = ST_WAIT; // RULE_02
                    else
                        next_state = ST_IDLE;
                end
            // leaving pulse mode while start is held must resume back-to-back conversions
            ST_HOLD:
                if (!start_lvl || !one_shot)
                    next_state = ST_IDLE; // RULE_02
            default:
                next_state = ST_IDLE;
        endcase
        if (pwr_down)
            next_state = ST_IDLE; // RULE_07
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state      <= ST_IDLE;
            dly_cnt    <= 22'h00_0000;
            conv_start <= 1'b0;
        end
        else
        begin
            state      <= next_state;
            conv_start <= (state == ST_WAIT) && (next_state == ST_CONV); // RULE_03
            if (next_state == ST_WAIT && state != ST_WAIT)
                dly_cnt <= dly_load; // RULE_03
            else if (dly_cnt != 22'h00_0000)
                dly_cnt <= dly_cnt - 22'h00_0001;
        end
    end

    assign conv_active = state == ST_WAIT || state == ST_CONV;

    // configuration outputs
    // one driver for the whole struct, so no tool sees several writers of one variable
    assign cfg = '{
        chop_en:                  mode_sel == MODE_CHOP,          // RULE_01
        ac_two_wire:              mode_sel == MODE_AC2,           // RULE_01
        ac_four_wire:             mode_sel == MODE_AC4,           // RULE_01
        soft_power_down:          pwr_down,                       // RULE_07
        status_byte_enable:       power_iface_reg[PWR_STAT_BIT],  // RULE_08
        crc_check_enable:         power_iface_reg[PWR_CRC_BIT],   // RULE_09
        serial_auto_reset_enable: power_iface_reg[PWR_ARST_BIT]   // RULE_10
    };

    // pin drive; a disconnected pin never drives the analog input
    wire [3:0]   pin_oe    = pin_con & ~pin_dir; // RULE_15 RULE_04 RULE_05
    assign pin = '{out: pin_dat & pin_oe, oe: pin_oe}; // RULE_06

    // checks
    logic [21:0] wait_len;
    logic [21:0] wait_exp;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_len <= 22'h00_0000;
            wait_exp <= 22'h00_0000;
        end
        else if (next_state == ST_WAIT && state != ST_WAIT)
        begin
            wait_len <= 22'h00_0000;
            wait_exp <= dly_load;
        end
        else if (state == ST_WAIT)
            wait_len <= wait_len + 22'h00_0001;
    end

    mode_decode_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_01
        wr_conv && pwdata[6:5] == MODE_CHOP |=> cfg.chop_en && !cfg.ac_two_wire && !cfg.ac_four_wire)
        else $error("chop mode not selected after write");

    delay_len_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_03
        conv_start |-> wait_len == wait_exp + 22'h00_0001)
        else $error("start delay length wrong");

    one_shot_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
        state == ST_CONV && conv_done && one_shot |=> state != ST_WAIT && !conv_start)
        else $error("pulse mode restarted a conversion");

    continuous_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
        state == ST_CONV && conv_done && !one_shot && start_ok |=> state == ST_WAIT)
        else $error("continuous mode did not restart");

    pin_oe_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_15
        wr_pin |=> pin.oe == ($past(pwdata[7:4]) & ~$past(pwdata[3:0])))
        else $error("pin drive enable wrong after config write");

    pin_data_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_06
        wr_pwr ##1 !wr_pin |-> pin.out == ($past(pwdata[3:0]) & pin.oe))
        else $error("pin level not driven from data bits");

    power_down_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_07
        pwr_down |=> state == ST_IDLE ##1 !conv_start)
        else $error("conversion running in power-down");

    crc_sticky_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_14
        checksum_error_flag && !clr_crc |=> checksum_error_flag)
        else $error("checksum error flag lost");

    crc_set_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
        crc_error && cfg.crc_check_enable |=> checksum_error_flag)
        else $error("checksum error not recorded");

    read_conv_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_13
        setup && !pwrite && hit_conv |=> prdata[7:0] == $past(conversion_mode_reg))
        else $error("conversion mode read wrong");

    hold_exit_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_02
        state == ST_HOLD && !one_shot |=> state != ST_HOLD)
        else $error("pulse hold kept after leaving pulse mode");

    cfg_follow_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_08
        wr_pwr |=> cfg[3:0] == $past(pwdata[7:4]))
        else $error("interface options not taken from write");

endmodule

`default_nettype wire

// [verification/amcr_far_model.sv]
// far-side model: modulator answering conversion starts, and the pin wires
`timescale 1ns/1ps
`default_nettype none

module amcr_far_model
    import amcr_pkg::*;
#(
    parameter int LAT = 5
)(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // converter handshake
    input  wire logic       conv_start,
    output logic            conv_done,
    // pin wires
    input  wire amcr_pin_t  pin,
    input  wire logic [3:0] ext,
    output logic [3:0]      pin_in
);
    int cnt;

    // a driven pin shows the device level, an undriven one the outside level
    assign pin_in = (pin.oe & pin.out) | (~pin.oe & ext);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt       <= 0;
            conv_done <= 1'h0;
        end
        else
        begin
            conv_done <= (cnt == 1);
            if (conv_start)
                cnt <= LAT;
            else if (cnt != 0)
                cnt <= cnt - 1;
        end
    end
endmodule

`default_nettype wire

// [verification/testbench.sv]
// self-checking bench for the converter mode configuration registers
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import amcr_pkg::*;
    // short start delays so the run stays brief
    localparam amcr_dly_t DLY = '{0, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 0, 0};

    logic        pclk, presetn, psel, penable, pwrite, start_pin, crc_error;
    logic        pready, pslverr, conv_done, conv_start, conv_active, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, seed, v;
    logic [3:0]  pin_in, ext;
    amcr_cfg_t   cfg;
    amcr_pin_t   pin;
    int          miscompares, tests_run, cyc, n0, n1;

    amcr_regs #(.DELAY_CYCLES(DLY)) u_amcr_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .start_pin(start_pin), .conv_done(conv_done),
        .conv_start(conv_start), .conv_active(conv_active), .crc_error(crc_error), .cfg(cfg),
        .pin_in(pin_in), .pin(pin));

    amcr_far_model u_amcr_far_model (.pclk(pclk), .presetn(presetn), .conv_start(conv_start),
        .conv_done(conv_done), .pin(pin), .ext(ext), .pin_in(pin_in));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [7:0] exp_pin(input logic [7:0] cd, input logic [3:0] dat);
        logic [3:0] oe;
        oe = cd[7:4] & ~cd[3:0];
        return {dat & oe, oe};
    endfunction

    // connected inputs read the outside level, all other bits the written value
    function automatic logic [3:0] exp_dat(input logic [7:0] cd, input logic [3:0] dat, input logic [3:0] e);
        return (cd[7:4] & cd[3:0] & e) | (~(cd[7:4] & cd[3:0]) & dat);
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // one apb transfer; the extra edge keeps back-to-back calls from double assignment
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
        psel    <= 1'h1;
        penable <= 1'h0;
        pwrite  <= w;
        paddr   <= {idx[5:0], 2'h0};
        pwdata  <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1)
            @(posedge pclk);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask

    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'h0, idx, 8'h00);
        chk(rd, {24'h0, exp});
    endtask

    // cycles from a conversion end to the next start pulse
    task automatic gap(output int n);
        n = 0;
        while (conv_done !== 1'h1)
            @(posedge pclk);
        while (conv_start !== 1'h1)
        begin
            @(posedge pclk);
            n++;
        end
    endtask

    task automatic crc_pulse();
        crc_error <= 1'h1;
        @(posedge pclk);
        crc_error <= 1'h0;
        @(posedge pclk);
    endtask

    initial
    begin
        pclk = 1'h0;
        forever #4 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            miscompares++;
            conclude();
        end
    end

    initial
    begin
        seed = 32'hA3D1;
        {presetn, psel, penable, pwrite, start_pin, crc_error} = 6'h0;
        {paddr, pwdata, ext} = 44'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        rdchk(IDX_CONV, RST_CONV);
        rdchk(IDX_PIN, RST_PIN);
        rdchk(IDX_PWR, RST_PWR);
        chk(32'({cfg, pin}), 32'h0);
        apb(1'h1, 8'h09, 8'hFF);
        apb(1'h0, 8'h09, 8'h00);
        chk({23'h0, err, rd[7:0]}, 32'h100);
        $display("test reset done");
        for (int m = 0; m < 4; m++)
        begin
            apb(1'h1, IDX_CONV, {1'h0, 2'(m), 5'h01});
            chk({29'h0, cfg[6:4]}, {29'h0, m == 1, m == 2, m == 3});
        end
        $display("test modes done");
        for (int i = 0; i < 8; i++)
        begin
            v = (i == 0) ? 32'h05FF_F0F0 : (i == 1) ? 32'h0A7F_0FFF : rnd();
            ext <= v[27:24];
            apb(1'h1, IDX_PIN, v[7:0]);
            apb(1'h1, IDX_PWR, v[15:8]);
            apb(1'h1, IDX_CONV, v[23:16]);
            rdchk(IDX_CONV, v[23:16]);
            rdchk(IDX_PIN, v[7:0]);
            rdchk(IDX_PWR, {v[15:12], exp_dat(v[7:0], v[11:8], v[27:24])});
            chk(32'(cfg[3:0]), 32'(v[15:12]));
            chk(32'(pin), 32'(exp_pin(v[7:0], v[11:8])));
        end
        $display("test registers done");
        apb(1'h1, IDX_PWR, 8'h00);
        start_pin <= 1'h1;
        for (int c = 0; c < 16; c += 1)
        begin
            if (c == 0 || c == 1 || c == 13 || c == 14)
            begin
                apb(1'h1, IDX_CONV, 8'(c));
                gap(n1);
                gap(n1);
                if (c == 0)
                    n0 = n1;
                else
                    chk(32'(n1 - n0), 32'(DLY[c]));
            end
        end
        $display("test delays done");
        start_pin <= 1'h0;
        apb(1'h1, IDX_CONV, 8'h12);
        repeat (40) @(posedge pclk);
        start_pin <= 1'h1;
        n1 = 0;
        repeat (80)
        begin
            @(posedge pclk);
            n1 += (conv_start === 1'h1);
        end
        chk(32'(n1), 32'h1);
        apb(1'h1, IDX_CONV, 8'h00);
        n1 = 0;
        repeat (20)
        begin
            @(posedge pclk);
            n1 += (conv_start === 1'h1);
        end
        chk(32'(n1 != 0), 32'h1);
        apb(1'h1, IDX_PWR, 8'h80);
        n1 = 0;
        repeat (40)
        begin
            @(posedge pclk);
            n1 += (conv_start !== 1'h0) + (conv_active !== 1'h0);
        end
        chk(32'(n1), 32'h0);
        $display("test conversion done");
        apb(1'h1, IDX_PWR, 8'h00);
        crc_pulse();
        apb(1'h0, IDX_STATUS, 8'h00);
        chk(32'(rd[6]), 32'h0);
        apb(1'h1, IDX_PWR, 8'h20);
        crc_pulse();
        repeat (5) @(posedge pclk);
        apb(1'h0, IDX_STATUS, 8'h00);
        chk(32'(rd[6]), 32'h1);
        apb(1'h0, IDX_STATUS, 8'h00);
        chk(32'(rd[6]), 32'h1);
        apb(1'h1, IDX_STATUS, 8'h40);
        apb(1'h0, IDX_STATUS, 8'h00);
        chk(32'(rd[6]), 32'h0);
        $display("test checksum flag done");
        conclude();
    end
endmodule

`default_nettype wire
